// ### regspace_decoder.v
// Register space decoder for a sixteen-pin port expander: pointer,
// module routing, read mux, pin role plan and slave address straps.
// Assumes a serial protocol engine on the same clock gives byte strobes,
// and that each functional module answers its read data combinationally.
// Assumes the strap pins are held steady through reset up to the last
// clock edge before it ends, since their last synchronised value is what is kept.
// Strobe, load and role request inputs come from logic on this clock,
// so they pass no synchroniser; only the reset and the straps do.
`timescale 1ns/10ps
`include "regspace_defines.vh"

module regspace_decoder (
  // Clock and reset
  input  wire        CLK_SYS_I,
  input  wire        ARST_N_I,
  // Protocol engine side
  input  wire        PTR_LOAD_I,
  input  wire [7:0]  PTR_VALUE_I,
  input  wire        WR_STB_I,
  input  wire [7:0]  WR_DATA_I,
  input  wire        RD_STB_I,
  output wire [7:0]  RD_DATA_O,
  output wire [6:0]  SLAVE_ADDR_O,
  output wire [7:0]  PTR_O,
  // Module side
  output reg  [7:0]  MOD_ADDR_O,
  output reg  [7:0]  MOD_WDATA_O,
  output reg  [6:0]  MOD_WR_O,
  output reg  [6:0]  MOD_RD_O,
  input  wire [7:0]  CLKPWR_RDATA_I,
  input  wire [7:0]  INTC_RDATA_I,
  input  wire [7:0]  PWM_RDATA_I,
  input  wire [7:0]  KEYPAD_RDATA_I,
  input  wire [7:0]  ROTATOR_RDATA_I,
  input  wire [7:0]  PORT_RDATA_I,
  // Pin role plan
  input  wire [15:0] KEYPAD_EN_I,
  input  wire [3:0]  PWM_EN_I,
  output reg  [31:0] PIN_ROLE_O,
  // Strap pins
  input  wire [2:0]  STRAP_PIN_I
);

  // Reset synchroniser
  reg       rst_meta;   // First stage
  reg       rst_n;      // Synchronised reset, active low
  // Strap synchroniser
  reg [2:0] strap_meta; // First stage
  reg [2:0] strap_sync; // Second stage
  reg [2:0] strap_addr; // Stored strap bits
  // Pointer and decode
  reg [7:0] ptr;        // Register pointer
  reg [7:0] next_ptr;   // Next pointer value
  wire [2:0] sel;       // Module select of current pointer
  wire       inc;       // Pointer advances in this range
  reg  [7:0] rdata;     // Read data mux result
  reg  [7:0] rd_data;   // Registered read data
  // Pin roles
  wire [31:0] next_role; // Role of each pin for the next edge
  genvar      g;         // Pin index for the role loop

  // Release reset through two flip-flops
  // Assertion is immediate; release waits two edges so that the pointer and
  // module-side flops leave reset in the same cycle; the role register does not wait
  always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Straps pass two flip-flops before use; no reset here, so that the
  // pins are still followed while the device is held in reset
  always @(posedge CLK_SYS_I) begin
    strap_meta <= STRAP_PIN_I;
    strap_sync <= strap_meta;
  end

  // Track straps while in reset, freeze at release
  // The internal reset lags the pin by two edges, so the value kept is
  // the one the straps had at the last edge before the pin released, as they lag two edges too
  always @(posedge CLK_SYS_I) begin
    if (!rst_n) begin
      strap_addr <= strap_sync;
    end
  end

  // Seven-bit slave address from stored straps
  assign SLAVE_ADDR_O = `SLAVE_BASE | {4'h0, strap_addr};

  // Range classifier on the pointer
  regspace_classify u_classify (
    .addr_i       (ptr),
    .module_sel_o (sel),
    .auto_inc_o   (inc)
  );

  // Pointer next value: load, advance or hold
  // A load wins over a strobe in the same cycle; the module strobe still
  // fires at the old pointer, but the pointer takes the loaded value
  always @* begin
    next_ptr = ptr;
    if (PTR_LOAD_I) begin
      next_ptr = PTR_VALUE_I;
    end else if ((WR_STB_I || RD_STB_I) && inc) begin
      next_ptr = ptr + 8'h01;
    end else begin
      next_ptr = ptr;
    end
  end

  // Pointer register
  // Held at zero until the synchronised reset lets go
  always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ptr <= 8'h00;
    end else if (!rst_n) begin
      ptr <= 8'h00;
    end else begin
      ptr <= next_ptr;
    end
  end

  assign PTR_O = ptr;

  // One-hot module strobe for a select code; the unmapped code has none
  function [6:0] sel_onehot;
    input [2:0] code; // Module select code
    begin
      if (code == `MOD_NONE) begin
        sel_onehot = 7'h00;
      end else begin
        sel_onehot = 7'h01 << code;
      end
    end
  endfunction

  // Read mux picks one module's byte
  // Unmapped space reads back zero; the byte is held until the next read
  always @* begin
    case (sel)
      `MOD_CLKPWR:  rdata = CLKPWR_RDATA_I;
      `MOD_INTC:    rdata = INTC_RDATA_I;
      `MOD_PWM:     rdata = PWM_RDATA_I;
      `MOD_KEYPAD:  rdata = KEYPAD_RDATA_I;
      `MOD_ROTATOR: rdata = ROTATOR_RDATA_I;
      `MOD_PORT:    rdata = PORT_RDATA_I;
      default:      rdata = 8'h00;
    endcase
  end

  // Register strobes to modules; only the selected one fires
  // Strobes, address and write byte are one cycle behind the pointer
  always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      MOD_ADDR_O  <= 8'h00;
      MOD_WDATA_O <= 8'h00;
      MOD_WR_O    <= 7'h00;
      MOD_RD_O    <= 7'h00;
      rd_data     <= 8'h00;
    end else if (!rst_n) begin
      MOD_ADDR_O  <= 8'h00;
      MOD_WDATA_O <= 8'h00;
      MOD_WR_O    <= 7'h00;
      MOD_RD_O    <= 7'h00;
      rd_data     <= 8'h00;
    end else begin
      MOD_ADDR_O  <= ptr;
      MOD_WDATA_O <= WR_DATA_I;
      // Unmapped select has no strobe bit, so writes vanish
      MOD_WR_O    <= WR_STB_I ? sel_onehot(sel) : 7'h00;
      MOD_RD_O    <= RD_STB_I ? sel_onehot(sel) : 7'h00;
      if (RD_STB_I) begin
        rd_data <= rdata;
      end
    end
  end

  assign RD_DATA_O = rd_data;

  // Pin roles: port by default, keypad over port, pulse-width over both on pins 0-3
  generate
    for (g = 0; g < `NUM_PINS; g = g + 1) begin : g_role
      if (g < `NUM_PWM_PINS) begin : g_pwm
        // Pulse-width beats keypad, keypad beats port
        assign next_role[2*g +: 2] = PWM_EN_I[g]    ? `ROLE_PWM    :
                                     KEYPAD_EN_I[g] ? `ROLE_KEYPAD : `ROLE_PORT;
      end else begin : g_kp
        // Upper pins have no pulse-width role
        assign next_role[2*g +: 2] = KEYPAD_EN_I[g] ? `ROLE_KEYPAD : `ROLE_PORT;
      end
    end
  endgenerate

  // Role register, one flop pair per pin
  always @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PIN_ROLE_O <= 32'h0000_0000;
    end else begin
      PIN_ROLE_O <= next_role;
    end
  end

endmodule

// ### regspace_defines.vh
// Constants for the register space decoder and pin role plan.
// Included by the decoder top and its address range classifier.
`ifndef REGSPACE_DEFINES_VH
`define REGSPACE_DEFINES_VH

// Module select codes, one-hot order
`define MOD_NONE     3'h0
`define MOD_CLKPWR   3'h1
`define MOD_INTC     3'h2
`define MOD_PWM      3'h3
`define MOD_KEYPAD   3'h4
`define MOD_ROTATOR  3'h5
`define MOD_PORT     3'h6

// Address range bounds
`define CLKPWR_LO_A  8'h00
`define CLKPWR_HI_A  8'h07
`define CLKPWR_LO_B  8'h80
`define CLKPWR_HI_B  8'h81
`define INTC_LO      8'h10
`define INTC_HI      8'h1f
`define PWM_INC_LO   8'h30
`define PWM_INC_HI   8'h37
`define PWM_FIX_LO   8'h38
`define PWM_FIX_HI   8'h3f
`define KEYPAD_LO    8'h60
`define KEYPAD_HI    8'h6f
`define ROTATOR_LO   8'h70
`define ROTATOR_HI   8'h77
`define PORT_LO      8'h82
`define PORT_HI      8'hbf

// Slave address base, strap bits fill the low three bits
`define SLAVE_BASE   7'h40

// Pin roles
`define ROLE_PORT    2'h0
`define ROLE_KEYPAD  2'h1
`define ROLE_PWM     2'h2

// Pin counts
`define NUM_PINS     16
`define NUM_PWM_PINS 4

`endif

// ### regspace_classify.v
// Address range classifier: module select and auto-increment flag.
// Purely combinational; fed from the decoder's pointer register.
`timescale 1ns/10ps
`include "regspace_defines.vh"

module regspace_classify (
  // Address in
  input  wire [7:0] addr_i,
  // Decode out
  output reg  [2:0] module_sel_o,
  output reg        auto_inc_o
);

  // Inclusive range test
  function in_range;
    input [7:0] a;
    input [7:0] lo;
    input [7:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // Each address maps to at most one module
  always @* begin
    module_sel_o = `MOD_NONE;  // Unmapped by default
    auto_inc_o   = 1'b0;
    if (in_range(addr_i, `CLKPWR_LO_A, `CLKPWR_HI_A) ||
        in_range(addr_i, `CLKPWR_LO_B, `CLKPWR_HI_B)) begin
      module_sel_o = `MOD_CLKPWR;
      auto_inc_o   = 1'b1;
    end else if (in_range(addr_i, `INTC_LO, `INTC_HI)) begin
      module_sel_o = `MOD_INTC;
      auto_inc_o   = 1'b1;
    end else if (in_range(addr_i, `PWM_INC_LO, `PWM_INC_HI)) begin
      module_sel_o = `MOD_PWM;
      auto_inc_o   = 1'b1;
    end else if (in_range(addr_i, `PWM_FIX_LO, `PWM_FIX_HI)) begin
      module_sel_o = `MOD_PWM;
      auto_inc_o   = 1'b0;
    end else if (in_range(addr_i, `KEYPAD_LO, `KEYPAD_HI)) begin
      module_sel_o = `MOD_KEYPAD;
      auto_inc_o   = 1'b1;
    end else if (in_range(addr_i, `ROTATOR_LO, `ROTATOR_HI)) begin
      module_sel_o = `MOD_ROTATOR;
      auto_inc_o   = 1'b1;
    end else if (in_range(addr_i, `PORT_LO, `PORT_HI)) begin
      module_sel_o = `MOD_PORT;
      auto_inc_o   = 1'b1;
    end
  end

endmodule

// ### regspace_mods.sv
// Stand-in for the six functional modules' read ports.
// Assumes the decoder samples these bytes at the pointer it drives.
`timescale 1ns/10ps
module regspace_mods (
  input  wire [7:0]  addr_i,
  output wire [47:0] rdata_o
);
  genvar k;
  // Each module answers one byte: address xor a per-module mask
  generate
    for (k = 0; k < 6; k = k + 1) begin : g_mod
      localparam [7:0] MASK = 8'h11 * (k + 1);
      assign rdata_o[8*k+:8] = addr_i ^ MASK;
    end
  endgenerate
endmodule

// ### regspace_decoder_sva.sv
// Checker for the register space decoder, bound to its top.
// Assumes strobes start at the third edge after reset release.
`timescale 1ns/10ps
module regspace_decoder_sva (
  input wire        CLK_SYS_I, ARST_N_I, PTR_LOAD_I, WR_STB_I, RD_STB_I,
  input wire [7:0]  WR_DATA_I, PTR_O, RD_DATA_O, MOD_WDATA_O, MOD_ADDR_O,
  input wire [6:0]  MOD_WR_O, MOD_RD_O, SLAVE_ADDR_O,
  input wire [31:0] PIN_ROLE_O,
  input wire [15:0] KEYPAD_EN_I,
  input wire [3:0]  PWM_EN_I
);
  reg  [1:0] up; // Edges since release
  wire       go = (up == 2'h3) && !PTR_LOAD_I;
  wire       st = go && (RD_STB_I || WR_STB_I);
  // Count edges after release, saturating
  always @(posedge CLK_SYS_I or negedge ARST_N_I)
    if (!ARST_N_I) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  // Mapped address
  function mp(input [7:0] a);
    mp = a < 8 || a == 128 || a == 129 || a[7:4] == 1 || a[7:4] == 3 || a[7:4] == 6
      || (a >= 112 && a < 120) || (a >= 130 && a < 192);
  endfunction
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!ARST_N_I);
  property p_unmap; st && !mp(PTR_O) |=> !MOD_RD_O && !MOD_WR_O && $stable(PTR_O); endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped access reached a module");
  property p_rdz; go && RD_STB_I && !mp(PTR_O) |=> RD_DATA_O == 8'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("unmapped read not zero");
  property p_inc; st && mp(PTR_O) && PTR_O[7:3] != 5'h07 |=> PTR_O == $past(PTR_O) + 8'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("pointer did not advance");
  property p_fix; st && PTR_O[7:3] == 5'h07 |=> $stable(PTR_O); endproperty
  a_fix: assert property (p_fix) else $error("pointer moved in fixed range");
  property p_intc; go && RD_STB_I && PTR_O[7:4] == 4'h1 |=>
    MOD_RD_O == 7'h04 && MOD_ADDR_O == $past(PTR_O); endproperty
  a_intc: assert property (p_intc) else $error("interrupt range misrouted");
  property p_wdata; go && WR_STB_I |=> MOD_WDATA_O == $past(WR_DATA_I); endproperty
  a_wdata: assert property (p_wdata) else $error("write byte lost");
  property p_slave; SLAVE_ADDR_O[6:3] == 4'h8; endproperty
  a_slave: assert property (p_slave) else $error("slave address base wrong");
  property p_keep; up == 2'h3 && $past(up) == 2'h3 |-> $stable(SLAVE_ADDR_O); endproperty
  a_keep: assert property (p_keep) else $error("slave address moved after reset");
  property p_rolehi; (PIN_ROLE_O & 32'haaaaaa00) == 32'h0; endproperty
  a_rolehi: assert property (p_rolehi) else $error("pulse role on upper pin");
  property p_role0; up == 2'h3 |=> PIN_ROLE_O[1:0] ==
    ($past(PWM_EN_I[0]) ? 2'h2 : $past(KEYPAD_EN_I[0]) ? 2'h1 : 2'h0); endproperty
  a_role0: assert property (p_role0) else $error("pin zero role wrong");
endmodule
bind regspace_decoder regspace_decoder_sva i_sva (.CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I),
  .PTR_LOAD_I(PTR_LOAD_I), .WR_STB_I(WR_STB_I), .RD_STB_I(RD_STB_I), .WR_DATA_I(WR_DATA_I),
  .PTR_O(PTR_O), .RD_DATA_O(RD_DATA_O), .MOD_WDATA_O(MOD_WDATA_O), .MOD_ADDR_O(MOD_ADDR_O),
  .MOD_WR_O(MOD_WR_O), .MOD_RD_O(MOD_RD_O), .SLAVE_ADDR_O(SLAVE_ADDR_O),
  .PIN_ROLE_O(PIN_ROLE_O), .KEYPAD_EN_I(KEYPAD_EN_I), .PWM_EN_I(PWM_EN_I));

// ### register_space_decode_pin_functions_test.sv
// Self-checking bench: address sweep, bursts, pin roles, straps.
// Assumes the module stand-in xors each address with its own mask.
`timescale 1ns/10ps
module register_space_decode_pin_functions_test;
  reg         clk = 1'b0, arst_n = 1'b0, ld = 1'b0, rd = 1'b0, wr = 1'b0; // Clock, strobes
  reg  [7:0]  pv = 8'h0, wd = 8'h0, p = 8'h0; // Load value, write byte, modelled pointer
  reg  [15:0] ke = 16'h0; // Keypad requests
  reg  [3:0]  pe = 4'h0;  // Pulse-width requests
  reg  [2:0]  st = 3'h0;  // Straps
  wire [7:0]  rdo, ptr, ma, mwd;
  wire [6:0]  sa, mwr, mrd;
  wire [31:0] role;
  wire [47:0] rdat;
  integer     seed = 54454, n_errors = 0, checks = 0, cyc = 0, a, i;
  always #50 clk = ~clk;
  regspace_decoder i_dut (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .PTR_LOAD_I(ld), .PTR_VALUE_I(pv),
    .WR_STB_I(wr), .WR_DATA_I(wd), .RD_STB_I(rd), .RD_DATA_O(rdo), .SLAVE_ADDR_O(sa), .PTR_O(ptr),
    .MOD_ADDR_O(ma), .MOD_WDATA_O(mwd), .MOD_WR_O(mwr), .MOD_RD_O(mrd),
    .CLKPWR_RDATA_I(rdat[7:0]), .INTC_RDATA_I(rdat[15:8]), .PWM_RDATA_I(rdat[23:16]),
    .KEYPAD_RDATA_I(rdat[31:24]), .ROTATOR_RDATA_I(rdat[39:32]), .PORT_RDATA_I(rdat[47:40]),
    .KEYPAD_EN_I(ke), .PWM_EN_I(pe), .PIN_ROLE_O(role), .STRAP_PIN_I(st));
  regspace_mods i_mods (.addr_i(ptr), .rdata_o(rdat));
  // Module code in the low bits, advance flag on top
  function [3:0] cls(input integer a);
    begin
      cls[2:0] = (a < 8 || a == 128 || a == 129) ? 3'd1 : (a >= 16 && a < 32) ? 3'd2 :
        (a >= 48 && a < 64) ? 3'd3 : (a >= 96 && a < 112) ? 3'd4 :
        (a >= 112 && a < 120) ? 3'd5 : (a >= 130 && a < 192) ? 3'd6 : 3'd0;
      cls[3] = cls[2:0] != 3'd0 && !(a >= 56 && a < 64);
    end
  endfunction
  task chk(input [31:0] s, input [31:0] e);
    begin
      checks = checks + 1;
      if (s !== e) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: seen %h want %h", $time, s, e);
      end
    end
  endtask
  task drv(input l, input r, input w, input [7:0] v);
    begin
      ld = l; rd = r; wr = w; pv = v; wd = $random(seed);
      @(posedge clk);
      #1;
    end
  endtask
  // One byte read or written at the modelled pointer
  task acc(input r);
    reg [3:0] c;
    begin
      c = cls(p);
      drv(1'b0, r, !r, p);
      chk(r ? mrd : mwr, c[2:0] ? 7'h1 << c[2:0] : 7'h0);
      chk(ma, p);
      if (r) chk(rdo, c[2:0] ? p ^ (8'h11 * c[2:0]) : 8'h0);
      else chk(mwd, wd);
      p = p + c[3];
      chk(ptr, p);
    end
  endtask
  // Reset with straps held steady, then disturb them
  task rst;
    begin
      arst_n = 1'b0; st = $random(seed);
      repeat (8) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (4) drv(1'b0, 1'b0, 1'b0, 8'h0);
      chk(sa, {4'h8, st});
      st = ~st;
      repeat (4) drv(1'b0, 1'b0, 1'b0, 8'h0);
      chk(sa, {4'h8, ~st});
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      n_errors = n_errors + 1;
      give_verdict;
    end
  end
  initial begin
    rst;
    $display("strap test done");
    for (a = 0; a < 256; a = a + 1) begin
      drv(1'b1, 1'b0, 1'b0, a[7:0]); p = a[7:0]; acc(1'b0);
      drv(1'b1, 1'b0, 1'b0, a[7:0]); p = a[7:0]; acc(1'b1);
    end
    $display("sweep test done");
    drv(1'b1, 1'b0, 1'b0, 8'h36); p = 8'h36;
    repeat (3) acc(1'b1);
    repeat (3) acc(1'b0);
    $display("burst test done");
    for (a = 0; a < 20; a = a + 1) begin
      ke = $random(seed); pe = $random(seed);
      drv(1'b0, 1'b0, 1'b0, 8'h0);
      for (i = 0; i < 16; i = i + 1) chk(role[2*i+:2], (i < 4 && pe[i]) ? 2 : ke[i] ? 1 : 0);
    end
    $display("role test done");
    rst;
    $display("second reset done");
    give_verdict;
  end
endmodule
